// file: inc/twrs_if.sv
// Purpose: Open-drain two-wire link between master and slave ends
// Assumes: External pull-ups hold both lines high when nobody pulls
// Notes:   A line is low when any enabled driver outputs low
`timescale 1ns/1ps
interface twrs_if;
    logic mst_scl_o;
    logic mst_scl_oe;
    logic mst_sda_o;
    logic mst_sda_oe;
    logic slv_sda_o;
    logic slv_sda_oe;
    logic scl;
    logic sda;

    assign scl = ~(mst_scl_oe & ~mst_scl_o);
    assign sda = ~((mst_sda_oe & ~mst_sda_o) | (slv_sda_oe & ~slv_sda_o));

    modport slv (input scl, input sda, output slv_sda_o, output slv_sda_oe);
    modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe, output mst_sda_o, output mst_sda_oe);
endinterface

// file: inc/twrs_pkg.sv
// Purpose: Shared constants and types for the two-wire register slave link
// Assumes: Both ends run on mclk at 40 MHz
// Notes:   Bus wire levels are resolved in the interface, never in the ends
package twrs_pkg;

    localparam logic [5:0] SLV_ADDR_HI     = 6'h26;
    localparam logic [7:0] REG_MAX_DEFAULT = 8'h59;
    localparam logic [3:0] BIT_LAST        = 4'h8;
    localparam logic [3:0] BIT_ACK         = 4'h8;

    // Master-made link clock; slave samples with two-flop synchronisers
    localparam int MCLK_PERIOD_NS = 25;
    localparam int SCL_PERIOD_NS  = 400;
    localparam int QUARTER_CYC    = SCL_PERIOD_NS / (4 * MCLK_PERIOD_NS);

    typedef enum logic [1:0] {
        KIND_ADDR = 2'h0,
        KIND_REG  = 2'h1,
        KIND_DATA = 2'h2
    } twrs_kind_type;

    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_STOP  = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_READ  = 2'h3
    } twrs_cmd_type;

endpackage

// file: logic/twrs_master.sv
// Purpose: Master end: runs start, stop, byte write and byte read commands
// Assumes: Nothing stretches the clock; the master alone drives it
// Notes:   Each bit spans four quarter periods of QUARTER mclk cycles
`timescale 1ns/1ps
module twrs_master #(
    parameter int QUARTER = twrs_pkg::QUARTER_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    twrs_if.mst                        bus,
    input  wire logic                  cmd_valid,
    input  wire twrs_pkg::twrs_cmd_type cmd_code,
    input  wire logic [7:0]            cmd_data,
    input  wire logic                  cmd_nack,
    output logic                       cmd_ready,
    output logic                       done,
    output logic [7:0]                 rx_data,
    output logic                       rx_ack
);
    import twrs_pkg::*;

    typedef enum logic [1:0] {
        MS_IDLE = 2'h1,
        MS_RUN  = 2'h2
    } twrs_mst_state_type;

    twrs_mst_state_type state_q;
    twrs_cmd_type       op_q;
    logic [7:0]         qcnt_q;
    logic [1:0]         step_q;
    logic [3:0]         bit_q;
    logic [8:0]         tx_q;
    logic [8:0]         rx_q;
    logic               scl_oe_q;
    logic               sda_oe_q;
    logic               ready_q;
    logic               done_q;
    logic [7:0]         rx_data_q;
    logic               rx_ack_q;
    logic               sda_in;
    logic               tick;
    logic               finish;

    twrs_sync #(
        .W (1)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .async_i (bus.sda),
        .level_o (sda_in),
        .rise_o  (),
        .fall_o  ()
    );

    assign tick   = (state_q == MS_RUN) && (qcnt_q == 8'(QUARTER - 1));
    assign finish = tick && step_q == 2'h3 &&
                    ((op_q == CMD_START) || (op_q == CMD_STOP) || (bit_q == BIT_ACK));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= MS_IDLE;
            ready_q <= 1'b1;
            op_q    <= CMD_STOP;
            tx_q    <= 9'h1FF;
        end else if (state_q == MS_IDLE && cmd_valid) begin
            state_q <= MS_RUN;
            ready_q <= 1'b0;
            op_q    <= cmd_code;
            tx_q    <= (cmd_code == CMD_WRITE) ? {cmd_data, 1'b1} : {8'hFF, cmd_nack};
        end else if (finish) begin
            state_q <= MS_IDLE;
            ready_q <= 1'b1;
        end else if (tick && step_q == 2'h3 && op_q != CMD_START && op_q != CMD_STOP) begin
            tx_q <= {tx_q[7:0], 1'b1};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            qcnt_q <= 8'h00;
            step_q <= 2'h0;
            bit_q  <= 4'h0;
        end else if (state_q == MS_IDLE) begin
            qcnt_q <= 8'h00;
            step_q <= 2'h0;
            bit_q  <= 4'h0;
        end else if (tick) begin
            qcnt_q <= 8'h00;
            step_q <= step_q + 2'h1;
            if (step_q == 2'h3) begin
                bit_q <= bit_q + 4'h1;
            end
        end else begin
            qcnt_q <= qcnt_q + 8'h01;
        end
    end

    // Data moves only with the clock low, except for the conditions
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (tick) begin
            unique case (op_q)
                CMD_START: begin
                    unique case (step_q)
                        2'h0: sda_oe_q <= 1'b0;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b1;
                        2'h3: scl_oe_q <= 1'b1;
                    endcase
                end
                CMD_STOP: begin
                    unique case (step_q)
                        2'h0: sda_oe_q <= 1'b1;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b0;
                        2'h3: sda_oe_q <= 1'b0;
                    endcase
                end
                CMD_WRITE, CMD_READ: begin
                    unique case (step_q)
                        2'h0: sda_oe_q <= ~tx_q[8];
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: scl_oe_q <= 1'b0;
                        2'h3: scl_oe_q <= 1'b1;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_q      <= 9'h000;
            done_q    <= 1'b0;
            rx_data_q <= 8'h00;
            rx_ack_q  <= 1'b0;
        end else begin
            done_q <= finish;
            if (tick && step_q == 2'h2 && (op_q == CMD_WRITE || op_q == CMD_READ)) begin
                rx_q <= {rx_q[7:0], sda_in};
            end
            if (finish && (op_q == CMD_WRITE || op_q == CMD_READ)) begin
                rx_data_q <= rx_q[8:1];
                rx_ack_q  <= ~rx_q[0];
            end
        end
    end

    assign cmd_ready      = ready_q;
    assign done           = done_q;
    assign rx_data        = rx_data_q;
    assign rx_ack         = rx_ack_q;
    assign bus.mst_scl_o  = 1'b0;
    assign bus.mst_scl_oe = scl_oe_q;
    assign bus.mst_sda_o  = 1'b0;
    assign bus.mst_sda_oe = sda_oe_q;
endmodule

// file: logic/twrs_slave.sv
// Purpose: Slave end: decodes link traffic into register bank accesses
// Assumes: Register bank outside answers reg_rd_data for reg_rd_addr combinationally
// Notes:   All link events seen through synchronisers, a few mclk late
`timescale 1ns/1ps
module twrs_slave #(
    parameter logic [7:0] REG_MAX = twrs_pkg::REG_MAX_DEFAULT
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    twrs_if.slv             bus,
    input  wire logic       addr_select_pin,
    output logic            reg_wr_en,
    output logic [7:0]      reg_wr_addr,
    output logic [7:0]      reg_wr_data,
    output logic [7:0]      reg_rd_addr,
    input  wire logic [7:0] reg_rd_data,
    output logic            selected
);
    import twrs_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_RX     = 6'h02,
        ST_ACK    = 6'h04,
        ST_TX     = 6'h08,
        ST_MACK   = 6'h10,
        ST_IGNORE = 6'h20
    } twrs_slv_state_type;

    twrs_slv_state_type state_q;
    twrs_kind_type      kind_q;
    logic [3:0]         cnt_q;
    logic [7:0]         shift_q;
    logic [7:0]         ptr_q;
    logic               rw_q;
    logic               sda_oe_q;
    logic               mack_q;
    logic               wr_en_q;
    logic [7:0]         wr_addr_q;
    logic [7:0]         wr_data_q;
    logic               sel_q;
    logic [2:0]         lvl;
    logic [2:0]         rise;
    logic [2:0]         fall;
    logic               scl_hi;
    logic               sda_in;
    logic               start_det;
    logic               stop_det;
    logic               byte_end;
    logic               addr_match;
    logic               accept;

    function automatic logic [7:0] ptr_next(input logic [7:0] p);
        ptr_next = (p >= REG_MAX) ? p : p + 8'h01;
    endfunction

    twrs_sync #(
        .W (3)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .async_i ({addr_select_pin, bus.sda, bus.scl}),
        .level_o (lvl),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    assign scl_hi    = lvl[0];
    assign sda_in    = lvl[1];
    // Data edges while clock high are conditions, never data
    assign start_det = fall[1] & scl_hi;
    assign stop_det  = rise[1] & scl_hi;
    assign byte_end  = (state_q == ST_RX) & fall[0] & (cnt_q == BIT_LAST);

    assign addr_match = (shift_q[7:1] == {SLV_ADDR_HI, lvl[2]});

    always_comb begin
        unique case (kind_q)
            KIND_ADDR: accept = addr_match;
            KIND_REG:  accept = (shift_q <= REG_MAX);
            default:   accept = 1'b1;
        endcase
    end

    // Stop beats start beats byte traffic
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
        end else if (start_det) begin
            state_q <= ST_RX;
        end else begin
            unique case (state_q)
                ST_RX: begin
                    if (byte_end) begin
                        state_q <= accept ? ST_ACK : ST_IGNORE;
                    end
                end
                ST_ACK: begin
                    if (fall[0]) begin
                        state_q <= rw_q ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (fall[0] && cnt_q == BIT_LAST) begin
                        state_q <= ST_MACK;
                    end
                end
                ST_MACK: begin
                    if (rise[0] && sda_in) begin
                        state_q <= ST_IGNORE;
                    end else if (fall[0] && mack_q) begin
                        state_q <= ST_TX;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    state_q <= state_q;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            kind_q <= KIND_ADDR;
            rw_q   <= 1'b0;
        end else if (start_det) begin
            kind_q <= KIND_ADDR;
            rw_q   <= 1'b0;
        end else if (byte_end && kind_q == KIND_ADDR && addr_match) begin
            rw_q <= shift_q[0];
        end else if (state_q == ST_ACK && fall[0] && !rw_q) begin
            kind_q <= (kind_q == KIND_ADDR) ? KIND_REG : KIND_DATA;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
        end else if (start_det) begin
            cnt_q <= 4'h0;
        end else if (state_q == ST_RX && rise[0] && cnt_q != BIT_LAST) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_ACK && fall[0]) begin
            cnt_q <= rw_q ? 4'h1 : 4'h0;
        end else if (state_q == ST_TX && fall[0] && cnt_q != BIT_LAST) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_MACK && fall[0] && mack_q) begin
            cnt_q <= 4'h1;
        end
    end

    // One register both receives and sends, MSB first
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 8'h00;
        end else if (state_q == ST_RX && rise[0]) begin
            shift_q <= {shift_q[6:0], sda_in};
        end else if ((state_q == ST_ACK && rw_q) || (state_q == ST_MACK && mack_q)) begin
            if (fall[0]) begin
                shift_q <= reg_rd_data;
            end
        end else if (state_q == ST_TX && fall[0] && cnt_q != BIT_LAST) begin
            shift_q <= {shift_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_RX:   if (byte_end) sda_oe_q <= accept;
                ST_ACK:  if (fall[0]) sda_oe_q <= rw_q & ~reg_rd_data[7];
                ST_TX:   if (fall[0]) sda_oe_q <= (cnt_q != BIT_LAST) & ~shift_q[6];
                ST_MACK: if (fall[0]) sda_oe_q <= mack_q & ~reg_rd_data[7];
                default: sda_oe_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mack_q <= 1'b0;
        end else if (state_q == ST_MACK && rise[0]) begin
            mack_q <= ~sda_in;
        end else if (state_q != ST_MACK) begin
            mack_q <= 1'b0;
        end
    end

    // Pointer holds across a repeated start so reads resume at the base
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= 8'h00;
        end else if (byte_end && kind_q == KIND_REG && accept) begin
            ptr_q <= shift_q;
        end else if (byte_end && kind_q == KIND_DATA) begin
            ptr_q <= ptr_next(ptr_q);
        end else if (state_q == ST_TX && fall[0] && cnt_q == BIT_LAST) begin
            ptr_q <= ptr_next(ptr_q);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= byte_end && kind_q == KIND_DATA && !start_det && !stop_det;
            if (byte_end && kind_q == KIND_DATA) begin
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sel_q <= 1'b0;
        end else if (byte_end && kind_q == KIND_ADDR) begin
            sel_q <= addr_match;
        end
    end

    assign reg_wr_en      = wr_en_q;
    assign reg_wr_addr    = wr_addr_q;
    assign reg_wr_data    = wr_data_q;
    assign reg_rd_addr    = ptr_q;
    assign selected       = sel_q;
    assign bus.slv_sda_o  = 1'b0;
    assign bus.slv_sda_oe = sda_oe_q;
endmodule

// file: logic/twrs_sync.sv
// Purpose: Two-flop synchroniser with edge detection
// Assumes: Inputs asynchronous to mclk
// Notes:   Edges come from the second stage only
`timescale 1ns/1ps
module twrs_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // Idle link lines are high, so reset to high avoids false edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
endmodule

// file: tb/tb.sv
// Purpose: Bench joining master and slave ends over one link
// Assumes: Default QUARTER of 4 and REG_MAX of 0x59
// Notes:   Register bank modelled here; reads answer combinationally
`timescale 1ns/1ps
module tb;
    import twrs_pkg::*;
    typedef struct {
        logic [7:0] base;
        logic [7:0] data;
        logic       sel;
    } twrs_row_type;
    logic         mclk;
    logic         reset_n;
    logic         addr_select_pin;
    logic         cmd_valid;
    twrs_cmd_type cmd_code;
    logic [7:0]   cmd_data;
    logic         cmd_nack;
    logic         cmd_ready;
    logic         done;
    logic [7:0]   rx_data;
    logic         rx_ack;
    logic         reg_wr_en;
    logic [7:0]   reg_wr_addr;
    logic [7:0]   reg_wr_data;
    logic [7:0]   reg_rd_addr;
    logic [7:0]   reg_rd_data;
    logic         selected;
    logic [7:0]   bank [0:255];
    logic [7:0]   last_wa;
    int           error_cnt;
    int           tests_run;
    int           wr_cnt;
    int           c0;
    // Patterns differ from their bit reversal, so LSB-first shows up
    twrs_row_type rows [3] = '{'{8'h00, 8'hC1, 1'b0}, '{8'h37, 8'h1E, 1'b1}, '{8'h59, 8'h6B, 1'b0}};
    logic [7:0]   burst [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

    twrs_if bus_if ();
    twrs_slave u_twrs_slave (.mclk(mclk), .reset_n(reset_n), .bus(bus_if), .addr_select_pin(addr_select_pin),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .selected(selected));
    twrs_master u_twrs_master (.mclk(mclk), .reset_n(reset_n), .bus(bus_if), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
        .done(done), .rx_data(rx_data), .rx_ack(rx_ack));
    twrs_checker u_twrs_checker (.mclk(mclk), .reset_n(reset_n), .mst_scl_o(bus_if.mst_scl_o),
        .mst_scl_oe(bus_if.mst_scl_oe), .mst_sda_o(bus_if.mst_sda_o), .mst_sda_oe(bus_if.mst_sda_oe),
        .slv_sda_o(bus_if.slv_sda_o), .slv_sda_oe(bus_if.slv_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    assign reg_rd_data = bank[reg_rd_addr];
    always @(posedge mclk) begin
        if (reg_wr_en === 1'b1) begin
            bank[reg_wr_addr] <= reg_wr_data;
            last_wa <= reg_wr_addr;
            wr_cnt <= wr_cnt + 1;
        end
    end

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk1(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask

    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // One command, held for one mclk edge without checking cmd_ready, then waited out under a bound
    task automatic run(input twrs_cmd_type c, input logic [7:0] d, input logic n);
        int k;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
        cmd_nack = n;
        @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 400) begin
            error_cnt++;
            $display("unexpected done: expected 1, seen %b", done);
        end
    endtask

    task automatic wbyte(input logic [7:0] d, input logic exp_ack);
        run(CMD_WRITE, d, 1'b0);
        chk1("slave ack", exp_ack, rx_ack);
    endtask

    task automatic rbyte(input logic n, input logic [7:0] e);
        run(CMD_READ, 8'h00, n);
        chk8("read data", e, rx_data);
    endtask

    task automatic open_wr(input logic [7:0] base, input logic base_ack);
        run(CMD_START, 8'h00, 1'b0);
        wbyte({SLV_ADDR_HI, addr_select_pin, 1'b0}, 1'b1);
        chk1("selected", 1'b1, selected);
        wbyte(base, base_ack);
    endtask

    task automatic open_rd(input logic [7:0] base);
        open_wr(base, 1'b1);
        run(CMD_START, 8'h00, 1'b0);
        wbyte({SLV_ADDR_HI, addr_select_pin, 1'b1}, 1'b1);
    endtask

    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end

    initial begin
        reset_n = 1'b0;
        addr_select_pin = 1'b0;
        cmd_valid = 1'b0;
        cmd_code = CMD_START;
        cmd_data = 8'h00;
        cmd_nack = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        wr_cnt = 0;
        last_wa = 8'h00;
        for (int i = 0; i < 256; i++) begin
            bank[i] = 8'hEE;
        end
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            addr_select_pin = rows[i].sel;
            repeat (4) @(negedge mclk);
            c0 = wr_cnt;
            open_wr(rows[i].base, 1'b1);
            wbyte(rows[i].data, 1'b1);
            run(CMD_STOP, 8'h00, 1'b0);
            chk8("write count", 8'h01, 8'(wr_cnt - c0));
            chk8("write address", rows[i].base, last_wa);
            chk8("stored byte", rows[i].data, bank[rows[i].base]);
            chk1("selected after stop", 1'b0, selected);
            open_rd(rows[i].base);
            rbyte(1'b1, rows[i].data);
            run(CMD_STOP, 8'h00, 1'b0);
        end
        // Other address-select level must be ignored entirely
        c0 = wr_cnt;
        run(CMD_START, 8'h00, 1'b0);
        wbyte({SLV_ADDR_HI, 1'b1, 1'b0}, 1'b0);
        chk1("selected", 1'b0, selected);
        wbyte(8'h10, 1'b0);
        run(CMD_STOP, 8'h00, 1'b0);
        chk8("write count", 8'h00, 8'(wr_cnt - c0));
        // Burst past the top register: pointer sticks at the maximum
        c0 = wr_cnt;
        open_wr(8'h57, 1'b1);
        foreach (burst[i]) wbyte(burst[i], 1'b1);
        run(CMD_STOP, 8'h00, 1'b0);
        chk8("write count", 8'h04, 8'(wr_cnt - c0));
        chk8("write address", 8'h59, last_wa);
        chk8("stored byte", 8'h11, bank[8'h57]);
        chk8("stored byte", 8'h22, bank[8'h58]);
        chk8("stored byte", 8'h44, bank[8'h59]);
        open_rd(8'h57);
        rbyte(1'b0, 8'h11);
        rbyte(1'b0, 8'h22);
        rbyte(1'b0, 8'h44);
        rbyte(1'b1, 8'h44);
        repeat (4) @(negedge mclk);
        chk1("data line", 1'b1, bus_if.sda);
        run(CMD_STOP, 8'h00, 1'b0);
        // Base beyond the top register is refused and writes nothing
        c0 = wr_cnt;
        open_wr(8'h5A, 1'b0);
        wbyte(8'h77, 1'b0);
        run(CMD_STOP, 8'h00, 1'b0);
        chk8("write count", 8'h00, 8'(wr_cnt - c0));
        chk8("stored byte", 8'hEE, bank[8'h5A]);
        // Reset in mid-transfer, then a fresh write must work
        run(CMD_START, 8'h00, 1'b0);
        wbyte({SLV_ADDR_HI, addr_select_pin, 1'b0}, 1'b1);
        @(negedge mclk);
        reset_n = 1'b0;
        @(negedge mclk);
        chk1("selected", 1'b0, selected);
        chk1("write strobe", 1'b0, reg_wr_en);
        chk1("cmd ready", 1'b1, cmd_ready);
        chk1("rx ack", 1'b0, rx_ack);
        chk8("rx data", 8'h00, rx_data);
        chk1("clock line", 1'b1, bus_if.scl);
        chk1("data line", 1'b1, bus_if.sda);
        @(negedge mclk);
        reset_n = 1'b1;
        open_wr(8'h01, 1'b1);
        wbyte(8'h5E, 1'b1);
        run(CMD_STOP, 8'h00, 1'b0);
        chk8("stored byte", 8'h5E, bank[8'h01]);
        conclude();
    end
endmodule

// file: tb/twrs_checker.sv
// Purpose: Concurrent checks on the shared two-wire link
// Assumes: Master built with QUARTER = 4, so each clock phase spans 8 mclk
// Notes:   Sees wire signals only; register side judged by the bench
`timescale 1ns/1ps
module twrs_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic mst_scl_o,
    input wire logic mst_scl_oe,
    input wire logic mst_sda_o,
    input wire logic mst_sda_oe,
    input wire logic slv_sda_o,
    input wire logic slv_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_open_drain_zero: assert property (!mst_scl_o && !mst_sda_o && !slv_sda_o)
        else $error("open drain output value not zero");
    a_slave_moves_low: assert property ($changed(slv_sda_oe) |-> !scl)
        else $error("slave changed data while clock high");
    a_scl_high_span: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_scl_low_span: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_ack_stands: assert property (slv_sda_oe && $rose(scl) |-> slv_sda_oe [*8])
        else $error("slave drive dropped during clock high");
    a_conditions_master: assert property (scl && $past(scl) && $changed(sda)
        |-> !slv_sda_oe && !$past(slv_sda_oe))
        else $error("slave took part in a start or stop");
    a_start_quiet: assert property (scl && $fell(sda) |=> !slv_sda_oe [*8])
        else $error("slave drove data right after a start");
    a_stop_idle: assert property (scl && $rose(sda) |=> (scl && !slv_sda_oe) [*2])
        else $error("link not idle after a stop");
endmodule
